/* File: include/dbp_pkg.sv */
/*
  dbp_pkg: constants for the dual byte port block (third and fourth
  ports sharing pins with the external data bus).
  Assumes: 16-bit register addresses, 8-bit register data.
*/
package dbp_pkg;

  ////////////////////////////////////////////////////////////////////
  // register offsets (lower 16 address bits)
  localparam logic [15:0] DBP_OFS_P3_DIR   = 16'hffc4;
  localparam logic [15:0] DBP_OFS_P4_DIR   = 16'hffc5;
  localparam logic [15:0] DBP_OFS_P3_LATCH = 16'hffc6;
  localparam logic [15:0] DBP_OFS_P4_LATCH = 16'hffc7;
  localparam logic [15:0] DBP_OFS_P4_PULL  = 16'hffda;

  ////////////////////////////////////////////////////////////////////
  // reset and read-back values
  localparam logic [7:0] DBP_RST_DIR   = 8'h00;
  localparam logic [7:0] DBP_RST_LATCH = 8'h00;
  localparam logic [7:0] DBP_RST_PULL  = 8'h00;
  localparam logic [7:0] DBP_RD_DIR    = 8'hff; // write-only readback
  localparam logic [7:0] DBP_RD_NONE   = 8'h00; // unmapped / idle

  ////////////////////////////////////////////////////////////////////
  // operating mode numbers
  localparam logic [2:0] DBP_MODE_EXP_LO = 3'h1;
  localparam logic [2:0] DBP_MODE_EXP_HI = 3'h5;
  localparam logic [2:0] DBP_MODE_SC_LO  = 3'h6;
  localparam logic [2:0] DBP_MODE_SC_HI  = 3'h7;
  localparam logic [2:0] DBP_MODE_W16_A  = 3'h2;
  localparam logic [2:0] DBP_MODE_W16_B  = 3'h4;

endpackage

/* File: rtl/dbp_port.sv */
/*
  dbp_port: third and fourth 8-bit general ports with data bus sharing.
  Assumes: op_mode and area_bus_width_config are steady system levels,
  pin inputs synchronous to clk, bus controller drives bus_dout/bus_oe.
*/
// Functional notes
// - modes 1-5: port three is data bus
// - modes 6-7: direction bit picks pin role
// - third direction reads back all ones
// - third direction clears on reset, hard standby
// - soft standby: third gpio outputs hold their level
// - third data read: latch or live pin
// - third latch clears reset/hard standby, keeps soft
// - any 16-bit area selects 16-bit bus
// - 16-bit bus: port four is data bus
// - 8-bit bus or modes 6-7: direction rules
// - reset bus width follows mode number
// - fourth direction reads back all ones
// - fourth direction clears reset, keeps soft
// - soft standby: fourth gpio outputs hold
// - fourth data read: latch or pin, both
// - fourth latch clears reset/hard standby
// - pull-up when input and control set
// - pull-up control clears reset/hard standby
// - pull-ups off in reset, hard standby, 16-bit
`timescale 1ns/1ps
module dbp_port (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hw_standby,
  input  wire logic        sw_standby,
  input  wire logic [2:0]  op_mode,
  input  wire logic [7:0]  area_bus_width_config,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [15:0] bus_dout,
  input  wire logic        bus_oe,
  output logic      [15:0] bus_din,
  output logic             bus_wide16,
  input  wire logic [7:0]  p3_pin_in,
  output logic      [7:0]  p3_pin_out,
  output logic      [7:0]  p3_pin_oe,
  input  wire logic [7:0]  p4_pin_in,
  output logic      [7:0]  p4_pin_out,
  output logic      [7:0]  p4_pin_oe,
  output logic      [7:0]  p4_pullup
);

  ////////////////////////////////////////////////////////////////////
  // storage
  logic [7:0]  p3_dir_ff;
  logic [7:0]  p4_dir_ff;
  logic [7:0]  p3_latch_ff;
  logic [7:0]  p4_latch_ff;
  logic [7:0]  p4_pull_ff;
  logic        wide16_ff;
  logic [7:0]  rdata_ff;
  logic [15:0] bus_din_ff;
  logic [7:0]  p3_out_ff;
  logic [7:0]  p3_oe_ff;
  logic [7:0]  p4_out_ff;
  logic [7:0]  p4_oe_ff;
  logic [7:0]  p4_pu_ff;

  logic [7:0]  nxt_p3_out;
  logic [7:0]  nxt_p3_oe;
  logic [7:0]  nxt_p4_out;
  logic [7:0]  nxt_p4_oe;
  logic [7:0]  nxt_p4_pu;
  logic [7:0]  nxt_rdata;
  logic [15:0] nxt_bus_din;
  logic        nxt_wide16;

  ////////////////////////////////////////////////////////////////////
  // mode decode, combinational from inputs and the bus width flop
  wire clr       = rst | hw_standby;
  wire mode_exp  = (op_mode >= dbp_pkg::DBP_MODE_EXP_LO) &&
                   (op_mode <= dbp_pkg::DBP_MODE_EXP_HI);
  wire mode_sc   = (op_mode >= dbp_pkg::DBP_MODE_SC_LO) &&
                   (op_mode <= dbp_pkg::DBP_MODE_SC_HI);
  wire mode_w16  = (op_mode == dbp_pkg::DBP_MODE_W16_A) ||
                   (op_mode == dbp_pkg::DBP_MODE_W16_B);
  wire any_w16   = |area_bus_width_config;
  wire p3_bus    = mode_exp;
  wire p3_gpio   = mode_sc;
  wire p4_bus    = mode_exp & wide16_ff;
  wire p4_gpio   = mode_sc | (mode_exp & ~wide16_ff);

  ////////////////////////////////////////////////////////////////////
  // register bus decode
  wire hit_p3d = reg_addr == dbp_pkg::DBP_OFS_P3_DIR;
  wire hit_p4d = reg_addr == dbp_pkg::DBP_OFS_P4_DIR;
  wire hit_p3l = reg_addr == dbp_pkg::DBP_OFS_P3_LATCH;
  wire hit_p4l = reg_addr == dbp_pkg::DBP_OFS_P4_LATCH;
  wire hit_p4p = reg_addr == dbp_pkg::DBP_OFS_P4_PULL;

  // mixed read: latch where output, live pin where input
  wire [7:0] p3_view = (p3_dir_ff & p3_latch_ff) |
                       (~p3_dir_ff & p3_pin_in);
  wire [7:0] p4_view = (p4_dir_ff & p4_latch_ff) |
                       (~p4_dir_ff & p4_pin_in);

  // read data stands only in the cycle after the strobe
  assign nxt_rdata = !reg_rd ? dbp_pkg::DBP_RD_NONE :
                     (hit_p3d | hit_p4d) ? dbp_pkg::DBP_RD_DIR :
                     hit_p3l ? p3_view :
                     hit_p4l ? p4_view :
                     hit_p4p ? p4_pull_ff :
                     dbp_pkg::DBP_RD_NONE;

  // bus width: mode-driven default while cleared, config after
  assign nxt_wide16 = clr ? mode_w16 : any_w16;

  // bus read path: upper byte from port three, lower from port four in 16-bit bus mode, else zero
  assign nxt_bus_din = {p3_pin_in, p4_bus ? p4_pin_in : 8'h00};

  ////////////////////////////////////////////////////////////////////
  // per-pin drive, one generate loop for both ports
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pin
      // third port: bus owns pins in expanded modes
      assign nxt_p3_oe[gi] =
        clr        ? 1'b0 :
        sw_standby ? (p3_gpio & p3_oe_ff[gi]) :
        p3_bus     ? bus_oe :
        p3_gpio    ? p3_dir_ff[gi] :
        1'b0;
      assign nxt_p3_out[gi] =
        clr        ? 1'b0 :
        sw_standby ? p3_out_ff[gi] :
        p3_bus     ? bus_dout[8+gi] :
        p3_latch_ff[gi];
      // fourth port: low data byte only in 16-bit bus mode
      assign nxt_p4_oe[gi] =
        clr        ? 1'b0 :
        sw_standby ? (p4_gpio & p4_oe_ff[gi]) :
        p4_bus     ? bus_oe :
        p4_gpio    ? p4_dir_ff[gi] :
        1'b0;
      assign nxt_p4_out[gi] =
        clr        ? 1'b0 :
        sw_standby ? p4_out_ff[gi] :
        p4_bus     ? bus_dout[gi] :
        p4_latch_ff[gi];
      // pull-up never fights the data bus, nor a driven pin unless a write clears its direction bit in the cycle before soft standby
      assign nxt_p4_pu[gi] =
        !clr & p4_gpio & ~p4_dir_ff[gi] & p4_pull_ff[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // software registers; soft standby freezes them since the cpu is halted, hard standby clears them
  always_ff @(posedge clk)
  begin
    if (clr)
    begin
      p3_dir_ff   <= dbp_pkg::DBP_RST_DIR;
      p4_dir_ff   <= dbp_pkg::DBP_RST_DIR;
      p3_latch_ff <= dbp_pkg::DBP_RST_LATCH;
      p4_latch_ff <= dbp_pkg::DBP_RST_LATCH;
      p4_pull_ff  <= dbp_pkg::DBP_RST_PULL;
    end
    else if (reg_wr && !sw_standby)
    begin
      if (hit_p3d)
        p3_dir_ff <= reg_wdata;
      if (hit_p4d)
        p4_dir_ff <= reg_wdata;
      if (hit_p3l)
        p3_latch_ff <= reg_wdata;
      if (hit_p4l)
        p4_latch_ff <= reg_wdata;
      if (hit_p4p)
        p4_pull_ff <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // output stage: every port leaves from a flop
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_ff   <= dbp_pkg::DBP_RD_NONE;
      bus_din_ff <= 16'h0000;
    end
    else
    begin
      rdata_ff   <= nxt_rdata;
      bus_din_ff <= nxt_bus_din;
    end
  end

  // pin flops take their cleared value from the nxt_ terms
  always_ff @(posedge clk)
  begin
    wide16_ff <= nxt_wide16;
    p3_out_ff <= nxt_p3_out;
    p3_oe_ff  <= nxt_p3_oe;
    p4_out_ff <= nxt_p4_out;
    p4_oe_ff  <= nxt_p4_oe;
    p4_pu_ff  <= nxt_p4_pu;
  end

  assign reg_rdata  = rdata_ff;
  assign bus_din    = bus_din_ff;
  assign bus_wide16 = wide16_ff;
  assign p3_pin_out = p3_out_ff;
  assign p3_pin_oe  = p3_oe_ff;
  assign p4_pin_out = p4_out_ff;
  assign p4_pin_oe  = p4_oe_ff;
  assign p4_pullup  = p4_pu_ff;

  ////////////////////////////////////////////////////////////////////
  // checks
  property p_p3_dir_rd;
    @(posedge clk) disable iff (rst)
    (reg_rd && reg_addr == dbp_pkg::DBP_OFS_P3_DIR) |=> reg_rdata == 8'hff;
  endproperty
  a_p3_dir_rd: assert property (p_p3_dir_rd)
    else $error("third direction read not all ones");

  property p_p4_dir_rd;
    @(posedge clk) disable iff (rst)
    (reg_rd && reg_addr == dbp_pkg::DBP_OFS_P4_DIR) |=> reg_rdata == 8'hff;
  endproperty
  a_p4_dir_rd: assert property (p_p4_dir_rd)
    else $error("fourth direction read not all ones");

  property p_p3_bus_oe;
    @(posedge clk) disable iff (rst)
    (mode_exp && !hw_standby && !sw_standby)
      |=> p3_pin_oe == {8{$past(bus_oe)}};
  endproperty
  a_p3_bus_oe: assert property (p_p3_bus_oe)
    else $error("third port not following data bus");

  property p_p3_gpio_oe;
    @(posedge clk) disable iff (rst)
    (mode_sc && !hw_standby && !sw_standby)
      |=> p3_pin_oe == $past(p3_dir_ff);
  endproperty
  a_p3_gpio_oe: assert property (p_p3_gpio_oe)
    else $error("third port drive differs from direction");

  property p_p3_clear;
    @(posedge clk)
    (rst || hw_standby) |=> (p3_dir_ff == 8'h00 && p3_latch_ff == 8'h00);
  endproperty
  a_p3_clear: assert property (p_p3_clear)
    else $error("third port registers not cleared");

  property p_p3_view;
    @(posedge clk) disable iff (rst)
    (reg_rd && reg_addr == dbp_pkg::DBP_OFS_P3_LATCH)
      |=> reg_rdata == (($past(p3_dir_ff) & $past(p3_latch_ff)) |
                        (~$past(p3_dir_ff) & $past(p3_pin_in)));
  endproperty
  a_p3_view: assert property (p_p3_view)
    else $error("third port data read mixes wrongly");

  property p_p3_hold;
    @(posedge clk) disable iff (rst || hw_standby)
    (sw_standby && mode_sc && $past(sw_standby))
      |-> $stable(p3_pin_out) && $stable(p3_pin_oe);
  endproperty
  a_p3_hold: assert property (p_p3_hold)
    else $error("third port moved in soft standby");

  property p_w16_reset;
    @(posedge clk)
    rst |=> bus_wide16 == $past(mode_w16);
  endproperty
  a_w16_reset: assert property (p_w16_reset)
    else $error("bus width after reset wrong for mode");

  property p_p4_bus;
    @(posedge clk) disable iff (rst)
    (mode_exp && bus_wide16 && !hw_standby && !sw_standby)
      |=> p4_pin_oe == {8{$past(bus_oe)}} && p4_pullup == 8'h00;
  endproperty
  a_p4_bus: assert property (p_p4_bus)
    else $error("fourth port not on data bus in 16-bit mode");

  property p_p4_pull;
    @(posedge clk) disable iff (rst)
    (!hw_standby && (mode_sc || (mode_exp && !bus_wide16)))
      |=> p4_pullup == ($past(p4_pull_ff) & ~$past(p4_dir_ff));
  endproperty
  a_p4_pull: assert property (p_p4_pull)
    else $error("fourth port pull-up wrong");

  property p_pull_off;
    @(posedge clk)
    (rst || hw_standby) |=> p4_pullup == 8'h00 && p4_pull_ff == 8'h00;
  endproperty
  a_pull_off: assert property (p_pull_off)
    else $error("pull-ups not forced off");

  property p_p4_view;
    @(posedge clk) disable iff (rst)
    (reg_rd && reg_addr == dbp_pkg::DBP_OFS_P4_LATCH)
      |=> reg_rdata == (($past(p4_dir_ff) & $past(p4_latch_ff)) |
                        (~$past(p4_dir_ff) & $past(p4_pin_in)));
  endproperty
  a_p4_view: assert property (p_p4_view)
    else $error("fourth port data read mixes wrongly");

  // gpio role of port four, either single chip or narrow bus
  property p_p4_gpio_oe;
    @(posedge clk) disable iff (rst)
    (!hw_standby && !sw_standby && (mode_sc || (mode_exp && !bus_wide16)))
      |=> p4_pin_oe == $past(p4_dir_ff);
  endproperty
  a_p4_gpio_oe: assert property (p_p4_gpio_oe)
    else $error("fourth port drive differs from direction");

  // only gpio pins freeze; bus-owned pins let go in standby
  property p_p4_hold;
    @(posedge clk) disable iff (rst || hw_standby)
    (sw_standby && $past(sw_standby) && (mode_sc || (mode_exp && !bus_wide16)))
      |-> $stable(p4_pin_out) && $stable(p4_pin_oe);
  endproperty
  a_p4_hold: assert property (p_p4_hold)
    else $error("fourth port moved in soft standby");

  property p_w16_cfg;
    @(posedge clk) disable iff (rst)
    !hw_standby |=> bus_wide16 == (|$past(area_bus_width_config));
  endproperty
  a_w16_cfg: assert property (p_w16_cfg)
    else $error("bus width not following area config");

  property p_p4_clear;
    @(posedge clk)
    (rst || hw_standby) |=> (p4_dir_ff == 8'h00 && p4_latch_ff == 8'h00);
  endproperty
  a_p4_clear: assert property (p_p4_clear)
    else $error("fourth port registers not cleared");

endmodule

/* File: tb/dbp_pin_model.sv */
/*
  dbp_pin_model: what sits on one 8-bit port's pins outside the chip.
  Assumes: oe high means the chip drives that pin; ext_en marks pins
  that the outside world drives; anything left floating wanders.
*/
`timescale 1ns/1ps
module dbp_pin_model (
  input  wire logic       clk,
  input  wire logic [7:0] oe,
  input  wire logic [7:0] out,
  input  wire logic [7:0] pu,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin
);
  logic [7:0] flt_ff = 8'h5a;

  ////////////////////////////////////////////////////////////////////
  // floating pins flip every cycle so a stale value never passes
  always_ff @(posedge clk)
    flt_ff <= ~flt_ff;

  // chip drive wins, then the outside driver, then pull-up or float
  assign pin = (oe & out) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pu | flt_ff));
endmodule

/* File: tb/tb_dual_byte_port_with_bus_sharing.sv */
/*
  tb_dual_byte_port_with_bus_sharing: self-checking bench for dbp_port.
  Assumes: reads answer one cycle later; pins settle within 3 cycles.
*/
`timescale 1ns/1ps
module tb_dual_byte_port_with_bus_sharing;
  logic        clk, rst, hw_standby, sw_standby, reg_wr, reg_rd, bus_oe, bus_wide16, rd_q;
  logic [2:0]  op_mode;
  logic [7:0]  cfg, reg_wdata, reg_rdata, ext3, ext4, ext_en, d3, d4, l3, l4, pu;
  logic [7:0]  p3_in, p3_out, p3_oe, p4_in, p4_out, p4_oe, p4_pullup;
  logic [15:0] reg_addr, bus_dout, bus_din;
  logic [7:0]  exp_q[$];
  int          bad_count, compares;

  dbp_port dut (.clk(clk), .rst(rst), .hw_standby(hw_standby), .sw_standby(sw_standby),
    .op_mode(op_mode), .area_bus_width_config(cfg), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bus_dout(bus_dout), .bus_oe(bus_oe), .bus_din(bus_din), .bus_wide16(bus_wide16),
    .p3_pin_in(p3_in), .p3_pin_out(p3_out), .p3_pin_oe(p3_oe), .p4_pin_in(p4_in),
    .p4_pin_out(p4_out), .p4_pin_oe(p4_oe), .p4_pullup(p4_pullup));
  dbp_pin_model m3 (.clk(clk), .oe(p3_oe), .out(p3_out), .pu(8'h00), .ext_en(ext_en),
    .ext_val(ext3), .pin(p3_in));
  dbp_pin_model m4 (.clk(clk), .oe(p4_oe), .out(p4_out), .pu(p4_pullup), .ext_en(ext_en),
    .ext_val(ext4), .pin(p4_in));

  ////////////////////////////////////////////////////////////////////
  // clock and watchdog; a hang counts as a mismatch
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #50000;
    bad_count++;
    give_verdict();
  end

  task automatic give_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp_rd(logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] reg_rdata exp %h got %h", e, g);
    end
  endtask

  task automatic cmp_pin(string nm, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  // bus master: one-cycle strobes, changed just after the edge
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [15:0] a, logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  // pin check after settling; out only matters where driven
  task automatic pins(logic [7:0] o3e, o3, o4e, o4, pe);
    repeat (3) @(posedge clk);
    @(negedge clk);
    cmp_pin("p3_pin_oe", o3e, p3_oe);
    cmp_pin("p3_pin_out", o3 & o3e, p3_out & p3_oe);
    cmp_pin("p4_pin_oe", o4e, p4_oe);
    cmp_pin("p4_pin_out", o4 & o4e, p4_out & p4_oe);
    cmp_pin("p4_pullup", pe, p4_pullup);
    // back onto the rising edge so the next stimulus is edge aligned
    @(posedge clk);
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge clk)
    rd_q <= reg_rd;
  always @(negedge clk)
    if (rd_q)
      cmp_rd(exp_q.pop_front(), reg_rdata);

  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    void'($urandom(32'h2f28768d));
    {rst, hw_standby, sw_standby, reg_wr, reg_rd, bus_oe} = 6'b100000;
    {op_mode, cfg, reg_addr, reg_wdata, bus_dout} = '0;
    ext_en = 8'hff;
    {ext3, ext4, d3, d4, l3, l4, pu} = 56'({$urandom, $urandom});
    // bus width loaded at reset follows the mode number; two edges per
    // mode gives exactly ten reset edges
    for (int m = 1; m <= 5; m++)
    begin
      op_mode <= m[2:0];
      @(posedge clk);
      @(negedge clk);
      cmp_pin("bus_wide16", {15'h0, m == 2 || m == 4}, {15'h0, bus_wide16});
      @(posedge clk);
    end
    op_mode <= 3'h7;
    rst <= 1'b0;
    rd(dbp_pkg::DBP_OFS_P3_DIR, 8'hff);
    rd(dbp_pkg::DBP_OFS_P4_DIR, 8'hff);
    rd(dbp_pkg::DBP_OFS_P3_LATCH, ext3);
    rd(dbp_pkg::DBP_OFS_P4_PULL, 8'h00);
    rd(16'hff00, dbp_pkg::DBP_RD_NONE);
    // single-chip gpio with random settings
    wr(dbp_pkg::DBP_OFS_P3_DIR, d3);
    wr(dbp_pkg::DBP_OFS_P4_DIR, d4);
    wr(dbp_pkg::DBP_OFS_P3_LATCH, l3);
    wr(dbp_pkg::DBP_OFS_P4_LATCH, l4);
    wr(dbp_pkg::DBP_OFS_P4_PULL, pu);
    rd(dbp_pkg::DBP_OFS_P3_LATCH, (d3 & l3) | (~d3 & ext3));
    rd(dbp_pkg::DBP_OFS_P4_LATCH, (d4 & l4) | (~d4 & ext4));
    rd(dbp_pkg::DBP_OFS_P4_PULL, pu);
    pins(d3, l3, d4, l4, pu & ~d4);
    // soft standby freezes outputs and refuses writes
    sw_standby <= 1'b1;
    ext3 <= ~ext3;
    wr(dbp_pkg::DBP_OFS_P3_LATCH, ~l3);
    wr(dbp_pkg::DBP_OFS_P4_DIR, ~d4);
    pins(d3, l3, d4, l4, pu & ~d4);
    sw_standby <= 1'b0;
    rd(dbp_pkg::DBP_OFS_P3_LATCH, (d3 & l3) | (~d3 & ext3));
    pins(d3, l3, d4, l4, pu & ~d4);
    // hard standby clears registers and turns pull-ups off
    op_mode <= 3'h6;
    hw_standby <= 1'b1;
    pins(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    hw_standby <= 1'b0;
    wr(dbp_pkg::DBP_OFS_P3_DIR, 8'hff);
    wr(dbp_pkg::DBP_OFS_P4_DIR, 8'hff);
    rd(dbp_pkg::DBP_OFS_P3_LATCH, 8'h00);
    rd(dbp_pkg::DBP_OFS_P4_LATCH, 8'h00);
    rd(dbp_pkg::DBP_OFS_P4_PULL, 8'h00);
    // expanded mode, 8-bit bus: port three is bus, port four gpio
    op_mode <= 3'h1;
    bus_oe <= 1'b1;
    bus_dout <= 16'($urandom);
    wr(dbp_pkg::DBP_OFS_P3_DIR, 8'h00);
    wr(dbp_pkg::DBP_OFS_P4_DIR, d4);
    wr(dbp_pkg::DBP_OFS_P4_LATCH, l4);
    wr(dbp_pkg::DBP_OFS_P4_PULL, pu);
    pins(8'hff, bus_dout[15:8], d4, l4, pu & ~d4);
    // any 16-bit area hands port four to the bus
    cfg <= 8'h01 << ($urandom % 8);
    pins(8'hff, bus_dout[15:8], 8'hff, bus_dout[7:0], 8'h00);
    @(negedge clk);
    cmp_pin("bus_wide16", 16'h1, {15'h0, bus_wide16});
    @(posedge clk);
    bus_oe <= 1'b0;
    pins(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    @(negedge clk);
    cmp_pin("bus_din", {ext3, ext4}, bus_din);
    @(posedge clk);
    rd(dbp_pkg::DBP_OFS_P4_LATCH, (d4 & l4) | (~d4 & ext4));
    repeat (3) @(posedge clk);
    give_verdict();
  end
endmodule
